// File: core/pcfc_core.sv
`timescale 1ns/1ps
// Functional notes
// - Inverted output is complement of in-phase outputs, except all low while waiting
// - Double-rate twice, half-rate half, all synchronous
// - Returned output sets in-phase to reference ratio
// - Divider choose high divides one, low two
// - Loop disabled: outputs follow reference, test mode
// - Reference select picks the active reference input
// - Enable low floats all clock outputs
// - After enable, outputs low, double-rate inverts reference
// - Outputs stay reset until a reference pulse
// - Enable/reset is asynchronous and active low
// - Lock high only in steady phase lock
// - Lock low on lost lock or loop disabled
// - Lock asserts within bounded time; the code only raises a timeout event if acquisition lasts LOCK_TMO_CYC cycles
module pcfc_core
  import pcfc_pkg::*;
#(
  parameter int PER_W = PCFC_PER_W,
  parameter int LOCK_TMO_CYC = PCFC_LOCK_TMO_CYC
) (
  input wire logic ref_clk_in, // System clock
  input wire logic rst_in, // Async reset, high
  input wire logic clk_en_in, // Freezes state when low
  input wire logic psel_in, // APB select
  input wire logic penable_in, // APB enable
  input wire logic pwrite_in, // APB direction
  input wire logic [7:0] paddr_in, // APB address
  input wire logic [31:0] pwdata_in, // APB write data
  output logic [31:0] prdata_out, // APB read data
  output logic pready_out, // APB ready
  output logic pslverr_out, // APB error
  input wire logic ref_src0_in, // Reference clock 0
  input wire logic ref_src1_in, // Reference clock 1
  input wire logic loop_return_in, // Returned output clock
  input wire logic oe_rst_n_in, // Output enable/reset, low
  output logic [4:0] inphase_clk_out, // In-phase clocks
  output logic inverted_clk_out, // Inverted clock
  output logic double_rate_clk_out, // Double-rate clock
  output logic half_rate_clk_out, // Half-rate clock
  output logic clk_oe_out, // Drive enable, all clocks
  output logic lock_out, // Loop settled
  output logic irq_out // Level interrupt
);

  localparam int TMO_W = $clog2(LOCK_TMO_CYC + 1);
  localparam logic [TMO_W-1:0] TMO_LAST = TMO_W'(LOCK_TMO_CYC - 1);
  localparam logic [PCFC_WIN_W-1:0] WIN_LAST = PCFC_WIN_W'(PCFC_LOCK_WIN_CYC - 1);
  localparam logic [PCFC_GOOD_W-1:0] GOOD_MAX = PCFC_GOOD_W'(PCFC_LOCK_GOOD);
  localparam logic [PER_W-1:0] REF_MAX = PER_W'(PCFC_REF_MAX_CYC);

  typedef struct packed {
    pcfc_mode_t mode;
    logic ref_d;
    logic fb_d;
    logic [PER_W-1:0] per_cnt;
    logic [PER_W-1:0] period;
    logic [PER_W-1:0] tick_cnt;
    logic vco_half;
    logic [2:0] ph;
    logic win_open;
    logic [PCFC_WIN_W-1:0] win_cnt;
    logic win_hit;
    logic [PCFC_GOOD_W-1:0] good_cnt;
    logic lock;
    logic [TMO_W-1:0] tmo_cnt;
    logic tmo_done;
    logic dbl_o;
    logic q_o;
    logic inv_o;
    logic half_o;
    logic [PCFC_EV_W-1:0] ev;
  } pcfc_core_st_t;

  pcfc_core_st_t st;
  pcfc_core_st_t next_st;

  logic core_rst;
  logic loop_en;
  logic ref_sel;
  logic divider_choose;
  logic [1:0] fb_sel;
  logic [1:0] fb_bit;
  logic ref_now;
  logic ref_rise;
  logic ref_fall;
  logic ref_edge;
  logic fb_rise;
  logic div2;
  logic [PER_W-1:0] per_next;
  logic [PER_W-1:0] tick_len;
  logic vco_tick;
  logic dist_tick;
  logic [31:0] status_w;

  // Counter value at which the returned output takes its rising edge
  function automatic logic [2:0] pcfc_align(input logic [2:0] ph, input logic [1:0] b);
    logic [2:0] bit_v;
    logic [2:0] mask;
    bit_v = 3'h1 << b;
    mask = (bit_v << 1) - 3'h1;
    return (ph & ~mask) | bit_v;
  endfunction

  // Oscillator half-tick length: reference period split by ratio and divider
  function automatic logic [PER_W-1:0] pcfc_tick_len(input logic [PER_W-1:0] per,
                                                      input logic [1:0] b,
                                                      input logic d2);
    logic [PER_W-1:0] t;
    t = per >> ({1'b0, b} + 3'h1 + {2'h0, d2});
    if (t == '0) begin
      t = PER_W'(1);
    end
    return t;
  endfunction

  // Enable/reset low clears the clock engine without a clock edge
  assign core_rst = rst_in | ~oe_rst_n_in;
  assign clk_oe_out = oe_rst_n_in & ~rst_in;

  // Reference choice and edge detection; pins are synchronous
  assign ref_now = ref_sel ? ref_src1_in : ref_src0_in;
  assign ref_rise = ref_now & ~st.ref_d;
  assign ref_fall = ~ref_now & st.ref_d;
  assign ref_edge = ref_rise | ref_fall;
  assign fb_rise = loop_return_in & ~st.fb_d;
  assign fb_bit = (fb_sel == PCFC_FB_RSVD) ? PCFC_FB_INPHASE : fb_sel;
  assign per_next = st.per_cnt + 1'b1;

  // Divide-by-two runs the oscillator twice as fast, then halves it
  assign div2 = ~divider_choose;
  assign tick_len = pcfc_tick_len(st.period, fb_bit, div2);
  assign vco_tick = (st.tick_cnt >= tick_len - 1'b1);
  assign dist_tick = vco_tick & (~div2 | st.vco_half);

  // Clock engine next state
  always_comb begin
    next_st = st;
    next_st.ev = '0;
    next_st.ref_d = ref_now;
    next_st.fb_d = loop_return_in;
    // Reference period in system cycles, saturating
    if (st.per_cnt != '1) begin
      next_st.per_cnt = per_next;
    end
    if (ref_rise) begin
      next_st.per_cnt = '0;
      next_st.period = per_next;
    end
    unique case (st.mode)
      PCFC_ST_WAIT: begin
        next_st.ph = 3'h0;
        // Nothing runs until the selected reference pulses
        if (ref_rise) begin
          next_st.mode = loop_en ? PCFC_ST_ACQ : PCFC_ST_TEST;
          next_st.ph = pcfc_align(3'h0, fb_bit);
          next_st.tick_cnt = '0;
          next_st.vco_half = 1'b0;
        end
      end
      PCFC_ST_TEST: begin
        // Oscillator bypassed: each reference edge steps the counter
        if (ref_edge) begin
          next_st.ph = st.ph + 3'h1;
        end
        if (loop_en) begin
          next_st.mode = PCFC_ST_ACQ;
          next_st.tick_cnt = '0;
          next_st.vco_half = 1'b0;
          next_st.good_cnt = '0;
        end
      end
      PCFC_ST_ACQ, PCFC_ST_LOCKED: begin
        if (!loop_en) begin
          next_st.mode = PCFC_ST_TEST;
          next_st.lock = 1'b0;
          next_st.good_cnt = '0;
          next_st.win_open = 1'b0;
          next_st.tmo_cnt = '0;
          next_st.tmo_done = 1'b0;
        end else begin
          // Ideal oscillator built from the measured period
          if (vco_tick) begin
            next_st.tick_cnt = '0;
            next_st.vco_half = ~st.vco_half;
          end else begin
            next_st.tick_cnt = st.tick_cnt + 1'b1;
          end
          if (dist_tick) begin
            next_st.ph = st.ph + 3'h1;
          end
          // Reference edge pulls the returned output into phase
          if (ref_rise) begin
            next_st.ph = pcfc_align(st.ph, fb_bit);
            next_st.tick_cnt = '0;
            next_st.vco_half = 1'b0;
            next_st.win_open = 1'b1;
            next_st.win_cnt = '0;
            next_st.win_hit = 1'b0;
            if (per_next > REF_MAX) begin
              next_st.ev[PCFC_EV_RANGE] = 1'b1;
            end
          end
          // Phase window: returned edge must follow reference closely
          if (st.win_open && !ref_rise) begin
            if (fb_rise) begin
              next_st.win_hit = 1'b1;
            end
            next_st.win_cnt = st.win_cnt + 1'b1;
            if (st.win_cnt == WIN_LAST) begin
              next_st.win_open = 1'b0;
              if (st.win_hit || fb_rise) begin
                if (st.good_cnt != GOOD_MAX) begin
                  next_st.good_cnt = st.good_cnt + 1'b1;
                end
                if (st.good_cnt == GOOD_MAX - 1'b1 && !st.lock) begin
                  next_st.lock = 1'b1;
                  next_st.mode = PCFC_ST_LOCKED;
                  next_st.ev[PCFC_EV_GAIN] = 1'b1;
                end
              end else begin
                next_st.good_cnt = '0;
                if (st.lock) begin
                  next_st.lock = 1'b0;
                  next_st.mode = PCFC_ST_ACQ;
                  next_st.ev[PCFC_EV_LOSS] = 1'b1;
                  next_st.tmo_cnt = '0;
                  next_st.tmo_done = 1'b0;
                end
              end
            end
          end
          // Acquisition deadline; flags a loop that fails to settle
          if (st.mode == PCFC_ST_ACQ && !st.tmo_done) begin
            if (st.tmo_cnt == TMO_LAST) begin
              next_st.tmo_done = 1'b1;
              next_st.ev[PCFC_EV_TMO] = 1'b1;
            end else begin
              next_st.tmo_cnt = st.tmo_cnt + 1'b1;
            end
          end
        end
      end
    endcase
    // Outputs: one counter feeds all once running so edges stay aligned; while waiting double-rate inverts the reference
    if (next_st.mode == PCFC_ST_WAIT) begin
      next_st.dbl_o = ~ref_now;
      next_st.q_o = 1'b0;
      next_st.inv_o = 1'b0;
      next_st.half_o = 1'b0;
    end else begin
      next_st.dbl_o = next_st.ph[0];
      next_st.q_o = next_st.ph[1];
      next_st.inv_o = ~next_st.ph[1];
      next_st.half_o = next_st.ph[2];
    end
  end

  always_ff @(posedge ref_clk_in or posedge core_rst) begin
    if (core_rst) begin
      st <= '0;
    end else if (clk_en_in) begin
      st <= next_st;
    end
  end

  assign inphase_clk_out = {5{st.q_o}};
  assign inverted_clk_out = st.inv_o;
  assign double_rate_clk_out = st.dbl_o;
  assign half_rate_clk_out = st.half_o;
  assign lock_out = st.lock;

  // Live status for software
  always_comb begin
    status_w = 32'h0000_0000;
    status_w[PCFC_STAT_LOCK] = st.lock;
    status_w[PCFC_STAT_RUN] = (st.mode != PCFC_ST_WAIT);
    status_w[PCFC_STAT_TEST] = (st.mode == PCFC_ST_TEST);
    status_w[PCFC_STAT_PER_LSB +: PER_W] = st.period;
  end

  // Registers survive enable/reset so software keeps its setup
  pcfc_regs u_regs (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .clk_en_in(clk_en_in),
    .psel_in(psel_in),
    .penable_in(penable_in),
    .pwrite_in(pwrite_in),
    .paddr_in(paddr_in),
    .pwdata_in(pwdata_in),
    .prdata_out(prdata_out),
    .pready_out(pready_out),
    .pslverr_out(pslverr_out),
    .status_in(status_w),
    .event_in(st.ev),
    .loop_en_out(loop_en),
    .ref_sel_out(ref_sel),
    .divider_choose_out(divider_choose),
    .fb_sel_out(fb_sel),
    .irq_out(irq_out)
  );

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (core_rst);

  inv_comp_a: assert property (
    (st.mode != PCFC_ST_WAIT) |-> (inverted_clk_out == ~inphase_clk_out[0])
  ) else $error("inverted output not complement of in-phase");

  half_sync_a: assert property (
    ($changed(st.half_o) && st.mode != PCFC_ST_WAIT &&
     $past(st.mode) != PCFC_ST_WAIT && !$past(ref_rise)) |-> $fell(st.q_o)
  ) else $error("half-rate moved without in-phase falling");

  dbl_sync_a: assert property (
    ($changed(st.q_o) && st.mode != PCFC_ST_WAIT &&
     $past(st.mode) != PCFC_ST_WAIT && !$past(ref_rise)) |-> $changed(st.dbl_o)
  ) else $error("in-phase moved without double-rate edge");

  oe_float_a: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    !oe_rst_n_in |-> (!clk_oe_out && st.mode == PCFC_ST_WAIT && !st.lock)
  ) else $error("outputs driven while enable/reset low");

  reset_low_a: assert property (
    (st.mode == PCFC_ST_WAIT) |-> (!st.q_o && !st.inv_o && !st.half_o)
  ) else $error("clock outputs not low while waiting");

  dbl_follow_a: assert property (
    (st.mode == PCFC_ST_WAIT && $past(st.mode) == PCFC_ST_WAIT &&
     $past(clk_en_in) && !$past(core_rst)) |-> (st.dbl_o == ~$past(ref_now))
  ) else $error("double-rate not inverse of reference");

  wait_pulse_a: assert property (
    (st.mode == PCFC_ST_WAIT && !ref_rise) |=> (st.mode == PCFC_ST_WAIT)
  ) else $error("left reset without reference pulse");

  test_follow_a: assert property (
    (st.mode == PCFC_ST_TEST && $past(st.mode) == PCFC_ST_TEST &&
     $past(clk_en_in) && !$past(core_rst)) |-> ($changed(st.dbl_o) == $past(ref_edge))
  ) else $error("test mode output not following reference");

  lock_need_a: assert property (
    $rose(lock_out) |-> (st.mode == PCFC_ST_LOCKED && st.good_cnt == GOOD_MAX)
  ) else $error("lock raised without steady phase lock");

  lock_drop_a: assert property (
    (!loop_en && clk_en_in) |=> !lock_out
  ) else $error("lock high with loop disabled");

  tmo_bound_a: assert property (
    $rose(st.tmo_done) |-> ($past(st.mode) == PCFC_ST_ACQ && st.tmo_cnt == TMO_LAST)
  ) else $error("lock deadline flagged at wrong count");

endmodule

// File: common/pcfc_pkg.sv
package pcfc_pkg;

  // APB register map, byte addresses
  localparam int PCFC_ADDR_W = 8;
  localparam logic [7:0] PCFC_CTRL_OFS = 8'h00;
  localparam logic [7:0] PCFC_STAT_OFS = 8'h04;
  localparam logic [7:0] PCFC_INT_STAT_OFS = 8'h08;
  localparam logic [7:0] PCFC_INT_MASK_OFS = 8'h0C;

  // Control register fields
  localparam int PCFC_CTRL_W = 5;
  localparam int PCFC_CTRL_LOOP_EN = 0;
  localparam int PCFC_CTRL_REF_SEL = 1;
  localparam int PCFC_CTRL_DIV = 2;
  localparam int PCFC_CTRL_FB_LSB = 3;
  localparam logic [4:0] PCFC_CTRL_RST = 5'h0D;

  // Status register fields
  localparam int PCFC_STAT_LOCK = 0;
  localparam int PCFC_STAT_RUN = 1;
  localparam int PCFC_STAT_TEST = 2;
  localparam int PCFC_STAT_PER_LSB = 8;

  // Event bits, shared by interrupt status and mask
  localparam int PCFC_EV_W = 4;
  localparam int PCFC_EV_GAIN = 0;
  localparam int PCFC_EV_LOSS = 1;
  localparam int PCFC_EV_TMO = 2;
  localparam int PCFC_EV_RANGE = 3;
  localparam logic [3:0] PCFC_INT_STAT_RST = 4'h0;
  localparam logic [3:0] PCFC_INT_MASK_RST = 4'h0;

  // Timing
  localparam int PCFC_PER_W = 16;
  localparam int PCFC_CLK_MHZ = 125;
  localparam int PCFC_CLK_PERIOD_NS = 8;
  localparam int PCFC_LOCK_TIME_MS = 10;
  localparam int PCFC_LOCK_TMO_CYC = PCFC_LOCK_TIME_MS * 1000 * PCFC_CLK_MHZ;
  localparam int PCFC_REF_MAX_NS = 200;
  localparam int PCFC_REF_MAX_CYC = PCFC_REF_MAX_NS / PCFC_CLK_PERIOD_NS;
  localparam int PCFC_LOCK_WIN_CYC = 3;
  localparam int PCFC_WIN_W = 2;
  localparam int PCFC_LOCK_GOOD = 8;
  localparam int PCFC_GOOD_W = 4;

  // Which output the board returns to the loop input
  typedef enum logic [1:0] {
    PCFC_FB_DOUBLE = 2'b00,
    PCFC_FB_INPHASE = 2'b01,
    PCFC_FB_HALF = 2'b10,
    PCFC_FB_RSVD = 2'b11
  } pcfc_fb_t;

  typedef enum logic [1:0] {
    PCFC_ST_WAIT = 2'b00,
    PCFC_ST_TEST = 2'b01,
    PCFC_ST_ACQ = 2'b10,
    PCFC_ST_LOCKED = 2'b11
  } pcfc_mode_t;

endpackage

// File: core/pcfc_regs.sv
`timescale 1ns/1ps
module pcfc_regs
  import pcfc_pkg::*;
(
  input wire logic ref_clk_in, // System clock
  input wire logic rst_in, // Async reset, high
  input wire logic clk_en_in, // Freezes state when low
  input wire logic psel_in, // APB select
  input wire logic penable_in, // APB enable
  input wire logic pwrite_in, // APB direction
  input wire logic [7:0] paddr_in, // APB address
  input wire logic [31:0] pwdata_in, // APB write data
  output logic [31:0] prdata_out, // APB read data
  output logic pready_out, // APB ready
  output logic pslverr_out, // APB error
  input wire logic [31:0] status_in, // Live core status
  input wire logic [3:0] event_in, // One-cycle event pulses
  output logic loop_en_out, // Loop enable
  output logic ref_sel_out, // Reference select
  output logic divider_choose_out, // High: divide by one
  output logic [1:0] fb_sel_out, // Returned output
  output logic irq_out // Level interrupt
);

  typedef struct packed {
    logic [PCFC_CTRL_W-1:0] ctrl;
    logic [PCFC_EV_W-1:0] int_stat;
    logic [PCFC_EV_W-1:0] int_mask;
    logic [31:0] rdata;
  } pcfc_regs_st_t;

  pcfc_regs_st_t st;
  pcfc_regs_st_t next_st;
  logic mapped;
  logic wr_acc;

  function automatic logic pcfc_is_mapped(input logic [7:0] a);
    return (a == PCFC_CTRL_OFS) || (a == PCFC_STAT_OFS) ||
           (a == PCFC_INT_STAT_OFS) || (a == PCFC_INT_MASK_OFS);
  endfunction

  // Zero-wait slave: every access phase completes at once
  assign mapped = pcfc_is_mapped(paddr_in);
  assign wr_acc = psel_in & penable_in & pwrite_in;
  assign pready_out = 1'b1;
  assign pslverr_out = psel_in & penable_in & ~mapped;

  // Register updates; read data is captured in the setup cycle
  always_comb begin
    next_st = st;
    next_st.int_stat = st.int_stat | event_in;
    if (wr_acc && paddr_in == PCFC_CTRL_OFS) begin
      next_st.ctrl = pwdata_in[PCFC_CTRL_W-1:0];
    end
    // Set beats clear so no event is lost
    if (wr_acc && paddr_in == PCFC_INT_STAT_OFS) begin
      next_st.int_stat = (st.int_stat & ~pwdata_in[PCFC_EV_W-1:0]) | event_in;
    end
    if (wr_acc && paddr_in == PCFC_INT_MASK_OFS) begin
      next_st.int_mask = pwdata_in[PCFC_EV_W-1:0];
    end
    if (psel_in && !penable_in) begin
      next_st.rdata = 32'h0000_0000;
      if (paddr_in == PCFC_CTRL_OFS) begin
        next_st.rdata[PCFC_CTRL_W-1:0] = st.ctrl;
      end else if (paddr_in == PCFC_STAT_OFS) begin
        next_st.rdata = status_in;
      end else if (paddr_in == PCFC_INT_STAT_OFS) begin
        next_st.rdata[PCFC_EV_W-1:0] = st.int_stat;
      end else if (paddr_in == PCFC_INT_MASK_OFS) begin
        next_st.rdata[PCFC_EV_W-1:0] = st.int_mask;
      end
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      st.ctrl <= PCFC_CTRL_RST;
      st.int_stat <= PCFC_INT_STAT_RST;
      st.int_mask <= PCFC_INT_MASK_RST;
      st.rdata <= 32'h0000_0000;
    end else if (clk_en_in) begin
      st <= next_st;
    end
  end

  assign prdata_out = st.rdata;
  assign loop_en_out = st.ctrl[PCFC_CTRL_LOOP_EN];
  assign ref_sel_out = st.ctrl[PCFC_CTRL_REF_SEL];
  assign divider_choose_out = st.ctrl[PCFC_CTRL_DIV];
  assign fb_sel_out = st.ctrl[PCFC_CTRL_FB_LSB +: 2];
  assign irq_out = |(st.int_stat & st.int_mask);

endmodule

// File: bench/pcfc_board.sv
`timescale 1ns/1ps
// Board side: two reference sources and the strap that returns one output
module pcfc_board #(
  parameter int HALF0 = 8, // Reference 0 half period, system cycles
  parameter int HALF1 = 5 // Reference 1 half period, system cycles
) (
  input wire logic ref_clk_in, // System clock
  input wire logic run0_in, // Reference 0 running
  input wire logic run1_in, // Reference 1 running, tester clock
  input wire logic [1:0] fb_sel_in, // Output strapped back
  input wire logic inphase_in, // One in-phase load
  input wire logic double_in, // Double-rate load
  input wire logic half_in, // Half-rate load
  output logic ref_src0_out, // Reference 0
  output logic ref_src1_out, // Reference 1
  output logic loop_return_out // Returned clock
);
  int cnt0 = 0;
  int cnt1 = 0;

  // Equal halves keep duty at half; a stopped source stands low instead of running free
  always @(posedge ref_clk_in) begin
    cnt0 <= run0_in ? (cnt0 + 1) % HALF0 : 0;
    cnt1 <= run1_in ? (cnt1 + 1) % HALF1 : 0;
    if (!run0_in) begin
      ref_src0_out <= 1'b0;
    end else if (cnt0 == HALF0 - 1) begin
      ref_src0_out <= ~ref_src0_out;
    end
    if (!run1_in) begin
      ref_src1_out <= 1'b0;
    end else if (cnt1 == HALF1 - 1) begin
      ref_src1_out <= ~ref_src1_out;
    end
  end

  // Strap of one clock output to the loop input
  always_comb begin
    case (fb_sel_in)
      2'b00: loop_return_out = double_in;
      2'b10: loop_return_out = half_in;
      default: loop_return_out = inphase_in;
    endcase
  end
endmodule

// File: bench/tb.sv
`timescale 1ns/1ps
module tb
  import pcfc_pkg::*;
;
  localparam int TMO = 400; // Lock wait bound, cycles
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic clk_en_in = 1'b1;
  logic psel_in = 1'b0;
  logic penable_in = 1'b0;
  logic pwrite_in = 1'b0;
  logic [7:0] paddr_in = 8'h00;
  logic [31:0] pwdata_in = 32'h00000000;
  logic oe_rst_n_in = 1'b1;
  logic run0 = 1'b0;
  logic run1 = 1'b0;
  logic [1:0] fb = 2'h1;
  logic [31:0] prdata_out;
  logic pready_out, pslverr_out, inverted_clk_out, double_rate_clk_out, half_rate_clk_out;
  logic clk_oe_out, lock_out, irq_out, ref0, ref1, ret, perr;
  logic [4:0] inphase_clk_out;
  logic [3:0] pv = 4'hF;
  logic [31:0] rdat;
  logic [31:0] mdl_ctrl = 32'h0000000D; // Register model
  logic [31:0] mdl_mask = 32'h00000000;
  int miscompares = 0, compares = 0, cycles = 0, n_ref, n_q, n_d, n_h, k, exp_q;
  int tot[4]; // Rising-edge totals: reference, in-phase, double, half
  logic [3:0] hold; // Outputs captured at a freeze
  integer seed = 32'h0F8DE1CE;
  int fbq[$] = '{1, 0, 2}; // Returned outputs visited in loop mode

  always #4 ref_clk_in = ~ref_clk_in;

  pcfc_core #(.LOCK_TMO_CYC(200)) u_pcfc_core (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .clk_en_in(clk_en_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .ref_src0_in(ref0), .ref_src1_in(ref1), .loop_return_in(ret), .oe_rst_n_in(oe_rst_n_in),
    .inphase_clk_out(inphase_clk_out), .inverted_clk_out(inverted_clk_out),
    .double_rate_clk_out(double_rate_clk_out), .half_rate_clk_out(half_rate_clk_out),
    .clk_oe_out(clk_oe_out), .lock_out(lock_out), .irq_out(irq_out));

  pcfc_board u_pcfc_board (.ref_clk_in(ref_clk_in), .run0_in(run0), .run1_in(run1), .fb_sel_in(fb),
    .inphase_in(inphase_clk_out[0]), .double_in(double_rate_clk_out), .half_in(half_rate_clk_out),
    .ref_src0_out(ref0), .ref_src1_out(ref1), .loop_return_out(ret));

  // Free-running rising-edge totals; measure takes differences so only one process writes each
  always @(posedge ref_clk_in) begin
    pv <= {(mdl_ctrl[1] ? ref1 : ref0), inphase_clk_out[0], double_rate_clk_out, half_rate_clk_out};
    tot[0] <= tot[0] + int'((mdl_ctrl[1] ? ref1 : ref0) & !pv[3]);
    tot[1] <= tot[1] + int'(inphase_clk_out[0] & !pv[2]);
    tot[2] <= tot[2] + int'(double_rate_clk_out & !pv[1]);
    tot[3] <= tot[3] + int'(half_rate_clk_out & !pv[0]);
  end

  // Hang guard, well above the few thousand cycles the run needs
  always @(posedge ref_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      $display("ERROR t=%0t timeout", $time);
      end_of_test();
    end
  end

  task end_of_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task chkreg(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t register read %h expected %h", $time, got, exp);
    end
  endtask

  task chkpin(input logic got, input logic exp, input string what);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t pin %s is %b expected %b", $time, what, got, exp);
    end
  endtask

  // Counts allow tol edges of slack at the window ends
  task chkcnt(input int got, input int exp, input int tol);
    compares++;
    if (got > exp + tol || got < exp - tol) begin
      miscompares++;
      $display("ERROR t=%0t edge count %0d expected %0d", $time, got, exp);
    end
  endtask

  // APB transfer; entered just after a rising edge, leaves one idle edge behind
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge ref_clk_in);
    penable_in <= 1'b1;
    @(posedge ref_clk_in);
    while (pready_out !== 1'b1) @(posedge ref_clk_in);
    r = prdata_out;
    e = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    @(posedge ref_clk_in);
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rdat, perr);
    if (a == PCFC_CTRL_OFS) mdl_ctrl = d & 32'h0000001F;
    if (a == PCFC_INT_MASK_OFS) mdl_mask = d & 32'h0000000F;
  endtask

  task rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000, rdat, perr);
    chkreg(rdat, exp);
  endtask

  // Counts edges over n cycles; checks output alignment only while the engine runs
  task measure(input int n, input logic run);
    int base[4];
    #1;
    base = tot;
    repeat (n) begin
      @(posedge ref_clk_in);
      #1;
      if (run) begin
        chkpin(inverted_clk_out, ~inphase_clk_out[0], "inverted");
        chkpin(inphase_clk_out === {5{inphase_clk_out[0]}}, 1'b1, "aligned");
      end
    end
    @(posedge ref_clk_in);
    n_ref = tot[0] - base[0];
    n_q = tot[1] - base[1];
    n_d = tot[2] - base[2];
    n_h = tot[3] - base[3];
  endtask

  // Main sequence
  initial begin
    repeat (12) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    @(posedge ref_clk_in);
    rd(PCFC_CTRL_OFS, 32'h0000000D);
    rd(PCFC_INT_STAT_OFS, 32'h00000000);
    rd(PCFC_INT_MASK_OFS, 32'h00000000);
    wr(PCFC_INT_MASK_OFS, $random(seed));
    rd(PCFC_INT_MASK_OFS, mdl_mask);
    wr(8'h10, 32'hFFFFFFFF);
    chkpin(perr, 1'b1, "slverr");
    rd(8'h10, 32'h00000000);
    wr(PCFC_INT_MASK_OFS, 32'h00000001);
    $display("test registers done");
    // Loop mode, each strap; divider low only on the last pass
    foreach (fbq[i]) begin
      fb <= 2'(fbq[i]);
      run0 <= 1'b1;
      wr(PCFC_CTRL_OFS, {27'h0, 2'(fbq[i]), i != 2, 2'b00});
      @(posedge ref_clk_in);
      chkpin(lock_out, 1'b0, "lock off");
      wr(PCFC_CTRL_OFS, mdl_ctrl | 32'h00000001);
      k = 0;
      while (lock_out !== 1'b1 && k < TMO) begin
        @(posedge ref_clk_in);
        k++;
      end
      chkpin(lock_out, 1'b1, "lock");
      // Locked and running, reference 0 period of two 8-cycle halves
      rd(PCFC_STAT_OFS, 32'h00001003);
      measure(160, 1'b1);
      exp_q = fbq[i] == 1 ? n_ref : fbq[i] == 0 ? n_ref / 2 : n_ref * 2;
      chkcnt(n_q, exp_q, 1);
      chkcnt(n_d, n_q * 2, 1);
      chkcnt(n_h, n_q / 2, 1);
      chkpin(irq_out, 1'b1, "irq");
      wr(PCFC_INT_STAT_OFS, 32'h0000000F);
      chkpin(irq_out, 1'b0, "irq clear");
    end
    // Wrong strap: the loop cannot settle, so loss and the deadline are flagged, both masked
    fb <= 2'h1;
    repeat (260) @(posedge ref_clk_in);
    chkpin(lock_out, 1'b0, "lock lost");
    chkpin(irq_out, 1'b0, "irq masked");
    rd(PCFC_INT_STAT_OFS, 32'h00000006);
    wr(PCFC_INT_STAT_OFS, 32'h0000000F);
    $display("test loop done");
    // Test mode: enable/reset, held reset without a pulse, second reference as test clock
    run0 <= 1'b0;
    wr(PCFC_CTRL_OFS, 32'h0000000C);
    oe_rst_n_in <= 1'b0;
    #1;
    chkpin(clk_oe_out, 1'b0, "drive enable");
    chkpin(lock_out, 1'b0, "lock test");
    @(posedge ref_clk_in);
    oe_rst_n_in <= 1'b1;
    repeat (20) begin
      @(posedge ref_clk_in);
      #1;
      chkpin(inphase_clk_out[0] | inverted_clk_out | half_rate_clk_out, 1'b0, "held low");
      chkpin(double_rate_clk_out, ~ref0, "double");
      chkpin(clk_oe_out, 1'b1, "drive enable");
    end
    @(posedge ref_clk_in);
    run0 <= 1'b1;
    wr(PCFC_CTRL_OFS, 32'h0000000E);
    measure(80, 1'b0);
    chkcnt(n_q, 0, 0);
    run1 <= 1'b1;
    measure(20, 1'b0);
    measure(200, 1'b1);
    chkcnt(n_q, n_ref / 2, 1);
    chkcnt(n_d, n_q * 2, 1);
    chkpin(lock_out, 1'b0, "lock test");
    // Running in test mode from reference 1, period of two 5-cycle halves
    rd(PCFC_STAT_OFS, 32'h00000A06);
    // Clock enable low: every output stands although the test clock keeps running
    clk_en_in <= 1'b0;
    @(posedge ref_clk_in);
    #1;
    hold = {inphase_clk_out[0], double_rate_clk_out, half_rate_clk_out, lock_out};
    repeat (30) begin
      @(posedge ref_clk_in);
      #1;
      chkpin(hold === {inphase_clk_out[0], double_rate_clk_out, half_rate_clk_out, lock_out}, 1'b1, "frozen");
    end
    @(posedge ref_clk_in);
    clk_en_in <= 1'b1;
    measure(60, 1'b1);
    chkcnt(n_q, n_ref / 2, 1);
    $display("test modes done");
    end_of_test();
  end
endmodule
